/* src/ssa_core.sv */
// host port and conversion sequencer of the sampling converter
//
// Operation
// - strobes act only while chip select is low.
// - write rise loads configuration and starts conversion; write fall samples.
// - busy output low throughout a conversion, high otherwise.
// - bus carries results on reads and configuration on writes.
// - every channel samples together on the write fall, selected or not.
// - eight sampling channels feed one converter; results go to result ram.
// - later starting writes convert the loaded channels without reloading.
// - each read returns the word at the pointer, then steps the pointer.
// - multi-channel write fall clears the result pointer to zero.
// - hold-off write with an address lets the next read fetch it.
// - address bits pick the channel configured and the read location.
// - sleep bit lowers power; writes still accepted, settings kept.
// - hold-off clear starts conversion; set only stores and sets pointer.
// - signed range bit picks bipolar or unipolar range per channel.
// - pair bit picks differential or single-ended per channel.
// - all bit clear converts configured channels; set converts one.
// - range and pair changes apply from the following conversion.
// - hard-wired mode starts a full multi-channel conversion in one write.
// - open mode input means programmed mode from the configuration word.
// - channels converted in turn from the lowest selected one.
`timescale 1ns/1ps
`default_nettype none
module ssa_core
(
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // host strobes, mode strap and converter clock
    input  wire logic                  cs_n,
    input  wire logic                  wr_n,
    input  wire logic                  rd_n,
    input  wire logic                  mode_prog,
    input  wire logic                  ext_clk,
    // shared bus, split into in, out and enable
    input  wire logic [ssa_pkg::DW-1:0] shared_bus_in,
    output var  logic [ssa_pkg::DW-1:0] shared_bus_out,
    output var  logic                  shared_bus_oe,
    // converter side
    input  wire logic [ssa_pkg::DW-1:0] conv_code,
    output var  logic                  sample_all,
    output var  logic [ssa_pkg::AW-1:0] conv_chan,
    output var  logic                  signed_range_select,
    output var  logic                  pair_input_select,
    output var  logic                  sleep_request,
    output var  logic                  busy_n
);
    import ssa_pkg::*;

    logic             wr_q_r;
    logic             rd_q_r;
    logic             ext_q_r;
    logic             wr_fall;
    logic             wr_rise;
    logic             rd_rise;
    logic             ext_edge;
    logic             hold_new;
    logic             single_new;
    logic             sleep_new;
    logic [AW-1:0]    ptr_new;
    logic             start_go;
    logic             conv_done;
    logic             ram_we;
    logic [NCH-1:0]   sel_mask;
    logic [NCH-1:0]   cfg_en_r;
    logic [NCH-1:0]   bip_pend_r;
    logic [NCH-1:0]   pair_pend_r;
    logic [NCH-1:0]   bip_act_r;
    logic [NCH-1:0]   pair_act_r;
    logic             single_r;
    logic [AW-1:0]    ptr_r;
    logic [AW-1:0]    ch_r;
    logic [CNT_W-1:0] cnt_r;
    ssa_state_t       st_r;
    ssa_state_t       st_nxt;

    // strobe edges, gated by chip select at the edge itself
    assign wr_fall    = ~cs_n & wr_q_r & ~wr_n;
    assign wr_rise    = ~cs_n & ~wr_q_r & wr_n;
    assign rd_rise    = ~cs_n & ~rd_q_r & rd_n;
    assign ext_edge   = ext_clk & ~ext_q_r;
    // configuration fields; a hard-wired part ignores the word
    assign hold_new   = mode_prog & shared_bus_in[HOLD_BIT];
    assign single_new = mode_prog & shared_bus_in[ALL_BIT];
    assign sleep_new  = mode_prog & shared_bus_in[SLEEP_BIT];
    assign ptr_new    = shared_bus_in[PTR_LSB +: AW];
    // a start while busy or with the word's sleep bit set is dropped; the word is still stored
    assign start_go   = wr_rise & ~hold_new & ~sleep_new
                        & (st_r == ST_IDLE);
    assign sel_mask   = mode_prog ? cfg_en_r : 8'hFF;
    assign conv_done  = (st_r == ST_CONV) & ext_edge & (cnt_r == CONV_LAST);
    assign ram_we     = conv_done;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            wr_q_r  <= 1'b1;
            rd_q_r  <= 1'b1;
            ext_q_r <= 1'b0;
        end
        else
        begin
            wr_q_r  <= wr_n | cs_n;
            rd_q_r  <= rd_n | cs_n;
            ext_q_r <= ext_clk;
        end
    end

    // configuration word: per-channel enables, range and pairing
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cfg_en_r    <= CFG_RST;
            bip_pend_r  <= CFG_RST;
            pair_pend_r <= CFG_RST;
            bip_act_r   <= CFG_RST;
            pair_act_r  <= CFG_RST;
            sleep_request <= 1'b0;
        end
        else if (wr_rise && mode_prog)
        begin
            // range and pair settings lag one write behind
            bip_act_r  <= bip_pend_r;
            pair_act_r <= pair_pend_r;
            bip_pend_r[ptr_new]  <= shared_bus_in[SIGNED_BIT];
            pair_pend_r[ptr_new] <= shared_bus_in[PAIR_BIT];
            if (!shared_bus_in[ALL_BIT])
            begin
                cfg_en_r[ptr_new] <= 1'b1;
            end
            // settings are kept across sleep
            sleep_request <= sleep_new;
        end
    end

    // result pointer; a clearing write fall or a loading write rise wins over a read step
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ptr_r <= PTR_RST;
        end
        else if (wr_fall && !single_new)
        begin
            ptr_r <= PTR_RST;
        end
        else if (wr_rise && (hold_new || single_new))
        begin
            ptr_r <= ptr_new;
        end
        else if (rd_rise)
        begin
            ptr_r <= ptr_r + 3'h1;
        end
    end

    // all track/holds sample on the write fall
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sample_all <= 1'b0;
        end
        else
        begin
            sample_all <= wr_fall;
        end
    end

    always_comb
    begin
        st_nxt = st_r;
        unique case (st_r)
            ST_IDLE:
            begin
                if (start_go)
                begin
                    st_nxt = single_new ? ST_CONV : ST_FIND;
                end
            end
            ST_FIND:
            begin
                if (sel_mask[ch_r])
                begin
                    st_nxt = ST_CONV;
                end
                else if (ch_r == CH_TOP)
                begin
                    st_nxt = ST_IDLE;
                end
            end
            ST_CONV:
            begin
                if (conv_done)
                begin
                    st_nxt = (single_r || ch_r == CH_TOP) ? ST_IDLE
                                                          : ST_FIND;
                end
            end
            default:
            begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    // sequencer: multi-channel runs scan upward from channel zero, one channel at a time; single runs go straight to the addressed channel
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            st_r     <= ST_IDLE;
            ch_r     <= PTR_RST;
            cnt_r    <= CNT_RST;
            single_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            if (st_r == ST_IDLE && start_go)
            begin
                single_r <= single_new;
                ch_r     <= single_new ? ptr_new : PTR_RST;
                cnt_r    <= CNT_RST;
            end
            else if (st_r == ST_FIND && !sel_mask[ch_r] && ch_r != CH_TOP)
            begin
                ch_r <= ch_r + 3'h1;
            end
            else if (st_r == ST_CONV && ext_edge)
            begin
                cnt_r <= conv_done ? CNT_RST : cnt_r + 5'h01;
                if (conv_done && !single_r && ch_r != CH_TOP)
                begin
                    ch_r <= ch_r + 3'h1;
                end
            end
        end
    end

    // busy follows the next state, so it rises with the last ram write
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            busy_n              <= 1'b1;
            conv_chan           <= PTR_RST;
            signed_range_select <= 1'b0;
            pair_input_select   <= 1'b0;
        end
        else
        begin
            busy_n              <= (st_nxt == ST_IDLE);
            conv_chan           <= ch_r;
            signed_range_select <= bip_act_r[ch_r];
            pair_input_select   <= pair_act_r[ch_r];
        end
    end

    // bus drive enable; data itself is the registered ram word
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            shared_bus_oe <= 1'b0;
        end
        else
        begin
            shared_bus_oe <= ~cs_n & ~rd_n;
        end
    end

    ssa_ram u_ram (
        .clk_sys (clk_sys),
        .rst     (rst),
        .we      (ram_we),
        .waddr   (ch_r),
        .wdata   (conv_code),
        .raddr   (ptr_r),
        .rdata_r (shared_bus_out)
    );

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_start;
        start_go && !single_new;
    endsequence

    sequence s_busy_low;
        !busy_n [*2];
    endsequence

    bus_drive_a: assert property (
        shared_bus_oe |-> $past(!cs_n && !rd_n))
        else $error("bus driven without chip select and read low");
    cs_gate_a: assert property (
        $rose(sample_all) |-> $past(!cs_n))
        else $error("sampling without chip select");
    sample_fall_a: assert property (
        wr_fall |=> sample_all ##1 !sample_all)
        else $error("write fall did not sample once");
    start_busy_a: assert property (
        s_start |=> s_busy_low)
        else $error("busy did not fall on conversion start");
    busy_state_a: assert property (
        busy_n == (st_r == ST_IDLE))
        else $error("busy disagrees with sequencer state");
    ptr_clear_a: assert property (
        wr_fall && !single_new |=> ptr_r == 3'h0)
        else $error("pointer not cleared on write fall");
    read_step_a: assert property (
        rd_rise && !wr_fall && !wr_rise |=> ptr_r == $past(ptr_r) + 3'h1)
        else $error("read did not step the pointer");
    hold_off_a: assert property (
        wr_rise && hold_new && busy_n |=> busy_n [*3])
        else $error("hold-off write started a conversion");
    ptr_load_a: assert property (
        wr_rise && hold_new |=> ptr_r == $past(ptr_new))
        else $error("hold-off write did not load the pointer");
    busy_end_a: assert property (
        $rose(busy_n) |-> $past(ram_we) || $past(st_r == ST_FIND))
        else $error("busy rose without a final result or empty scan");
endmodule
`default_nettype wire

/* src/ssa_pkg.sv */
// constants, field layout and state codes of the sampling converter port
package ssa_pkg;
    localparam int NCH         = 8;
    localparam int AW          = 3;
    localparam int DW          = 8;
    // configuration word field positions
    localparam int ALL_BIT     = 7;
    localparam int PAIR_BIT    = 6;
    localparam int SIGNED_BIT  = 5;
    localparam int HOLD_BIT    = 4;
    localparam int SLEEP_BIT   = 3;
    localparam int PTR_LSB     = 0;
    // conversion time per channel, counted in external clock edges
    localparam int CONV_TIME_NS    = 3600;
    localparam int EXT_CLK_KHZ     = 5000;
    localparam int CONV_EDGES      = (CONV_TIME_NS * EXT_CLK_KHZ) / 1000000;
    localparam int CNT_W           = 5;
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_EDGES - 1);
    // reset values and top channel
    localparam logic [NCH-1:0] CFG_RST  = 8'h00;
    localparam logic [AW-1:0]  PTR_RST  = 3'h0;
    localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
    localparam logic [AW-1:0]  CH_TOP   = 3'h7;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FIND = 3'b010,
        ST_CONV = 3'b100
    } ssa_state_t;
endpackage

/* src/ssa_ram.sv */
// result memory: eight words, registered read data
`timescale 1ns/1ps
`default_nettype none
module ssa_ram
    import ssa_pkg::*;
(
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // write side
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [DW-1:0]    wdata,
    // read side
    input  wire logic [AW-1:0]    raddr,
    output var  logic [DW-1:0]    rdata_r
);
    logic [DW-1:0] mem [NCH];

    // contents are not reset: like the part, results survive until overwritten
    always_ff @(posedge clk_sys)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rdata_r <= 8'h00;
        end
        else
        begin
            rdata_r <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

/* tb/ssa_host_model.sv */
// host processor model: strobes, bus drive and bus resolution
`timescale 1ns/1ps
`default_nettype none
module ssa_host_model
    import ssa_pkg::*;
(
    // clock
    input  wire logic                   clk_sys,
    // strobes
    output var  logic                   cs_n,
    output var  logic                   wr_n,
    output var  logic                   rd_n,
    // shared bus
    input  wire logic [ssa_pkg::DW-1:0] dev_out,
    input  wire logic                   dev_oe,
    output var  logic [ssa_pkg::DW-1:0] bus
);
    logic [DW-1:0] drv;
    logic          drv_en;
    logic [DW-1:0] last;

    // a released bus toggles each cycle so a stale value never reads back
    always_comb bus = dev_oe ? dev_out : (drv_en ? drv : ~last);
    always @(posedge clk_sys) last <= bus;

    initial
    begin
        cs_n = 1'b1;
        wr_n = 1'b1;
        rd_n = 1'b1;
        drv = 8'h00;
        drv_en = 1'b0;
        last = 8'h00;
    end

    // word stays on the bus past the rising strobe, where it is taken
    task automatic wr(input logic [DW-1:0] w, input logic sel);
        @(posedge clk_sys);
        cs_n <= ~sel;
        wr_n <= 1'b0;
        drv <= w;
        drv_en <= 1'b1;
        repeat (3) @(posedge clk_sys);
        wr_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        cs_n <= 1'b1;
        drv_en <= 1'b0;
    endtask

    task automatic rd(output logic [DW-1:0] d);
        @(posedge clk_sys);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        d = bus;
        rd_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        cs_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the sampling converter port
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ssa_pkg::*;
    logic          clk_sys;
    logic          rst;
    logic          ext_clk;
    logic [1:0]    ext_div;
    logic          mode_prog;
    logic          signed_range_select;
    logic          pair_input_select;
    logic          cs_n;
    logic          wr_n;
    logic          rd_n;
    logic [DW-1:0] bus;
    logic [DW-1:0] bus_out;
    logic          bus_oe;
    logic [DW-1:0] conv_code;
    logic          sample_all;
    logic [AW-1:0] conv_chan;
    logic          sleep_request;
    logic          busy_n;
    logic [3:0]    tag;
    logic [DW-1:0] d;
    logic [DW-1:0] rng_seen;
    logic [DW-1:0] pair_seen;
    logic          busy_prev;
    int            samp_cnt;
    int            busy_cnt;
    int            cyc;
    int            error_cnt;
    int            num_checks;

    // converter model: result names the channel and the conversion round
    assign conv_code = {tag, 1'b0, conv_chan};

    ssa_core ssa_core_i (
        .clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .wr_n(wr_n),
        .rd_n(rd_n), .mode_prog(mode_prog), .ext_clk(ext_clk),
        .shared_bus_in(bus), .shared_bus_out(bus_out),
        .shared_bus_oe(bus_oe), .conv_code(conv_code),
        .sample_all(sample_all), .conv_chan(conv_chan),
        .signed_range_select(signed_range_select),
        .pair_input_select(pair_input_select),
        .sleep_request(sleep_request), .busy_n(busy_n)
    );

    ssa_host_model ssa_host_model_i (
        .clk_sys(clk_sys), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
        .dev_out(bus_out), .dev_oe(bus_oe), .bus(bus)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // converter clock at a quarter of the system rate, moved on clock edges
    assign ext_clk = ext_div[1];

    always @(posedge clk_sys)
        ext_div <= ext_div + 2'h1;

    always @(posedge clk_sys)
    begin
        if (sample_all === 1'b1)
            samp_cnt++;
        if (busy_prev === 1'b1 && busy_n === 1'b0)
            busy_cnt++;
        busy_prev = busy_n;
        if (busy_n === 1'b0 && signed_range_select === 1'b1)
            rng_seen[conv_chan] = 1'b1;
        if (busy_n === 1'b0 && pair_input_select === 1'b1)
            pair_seen[conv_chan] = 1'b1;
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            results();
        end
    end

    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wait_idle;
        for (int i = 0; i < 2000 && busy_n !== 1'b1; i++)
            @(posedge clk_sys);
        // a conversion that never ends counts as a mismatch
        chk({7'h00, busy_n}, 8'h01);
        @(posedge clk_sys);
    endtask

    task automatic results;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        rst = 1'b1;
        mode_prog = 1'b1;
        ext_div = 2'h0;
        rng_seen = 8'h00;
        pair_seen = 8'h00;
        tag = 4'hA;
        busy_prev = 1'b1;
        samp_cnt = 0;
        busy_cnt = 0;
        cyc = 0;
        error_cnt = 0;
        num_checks = 0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk({7'h00, busy_n}, 8'h01);
        chk({7'h00, bus_oe}, 8'h00);
        for (int i = 0; i < NCH; i++)
            ssa_host_model_i.wr({4'h1, 1'b0, 3'(i)}, 1'b1);
        chk(8'(samp_cnt), 8'h08);
        chk(8'(busy_cnt), 8'h00);
        ssa_host_model_i.wr(8'h00, 1'b1);
        chk(8'(busy_cnt), 8'h01);
        wait_idle();
        chk({7'h00, busy_n}, 8'h01);
        for (int i = 0; i < NCH; i++)
        begin
            ssa_host_model_i.rd(d);
            chk(d, {tag, 1'b0, 3'(i)});
        end
        chk({7'h00, bus_oe}, 8'h00);
        // chip select high: strobes must have no effect
        ssa_host_model_i.wr(8'h00, 1'b0);
        chk(8'(samp_cnt), 8'h09);
        chk(8'(busy_cnt), 8'h01);
        // single channel conversion of channel 3
        tag = 4'hB;
        ssa_host_model_i.wr(8'h83, 1'b1);
        chk(8'(busy_cnt), 8'h02);
        wait_idle();
        ssa_host_model_i.rd(d);
        chk(d, 8'hB3);
        ssa_host_model_i.rd(d);
        chk(d, 8'hA4);
        // hold-off with address: pointer set, no conversion
        ssa_host_model_i.wr(8'h16, 1'b1);
        chk(8'(busy_cnt), 8'h02);
        ssa_host_model_i.rd(d);
        chk(d, 8'hA6);
        // sleep: no start, settings kept for the next run
        ssa_host_model_i.wr(8'h08, 1'b1);
        chk(8'(busy_cnt), 8'h02);
        chk({7'h00, sleep_request}, 8'h01);
        tag = 4'hC;
        ssa_host_model_i.wr(8'h00, 1'b1);
        chk(8'(busy_cnt), 8'h03);
        wait_idle();
        for (int i = 0; i < 2; i++)
        begin
            ssa_host_model_i.rd(d);
            chk(d, {4'hC, 1'b0, 3'(i)});
        end
        // range and pair changes lag one write behind
        rng_seen = 8'h00;
        pair_seen = 8'h00;
        ssa_host_model_i.wr(8'h35, 1'b1);
        chk(8'(busy_cnt), 8'h03);
        ssa_host_model_i.wr(8'h42, 1'b1);
        wait_idle();
        chk(rng_seen, 8'h20);
        chk(pair_seen, 8'h00);
        rng_seen = 8'h00;
        pair_seen = 8'h00;
        ssa_host_model_i.wr(8'h00, 1'b1);
        wait_idle();
        chk(rng_seen, 8'h20);
        chk(pair_seen, 8'h04);
        // hard-wired strap: word ignored, all channels converted
        mode_prog <= 1'b0;
        tag = 4'hD;
        ssa_host_model_i.wr(8'h9F, 1'b1);
        chk(8'(busy_cnt), 8'h06);
        wait_idle();
        for (int i = 0; i < NCH; i++)
        begin
            ssa_host_model_i.rd(d);
            chk(d, {4'hD, 1'b0, 3'(i)});
        end
        results();
    end
endmodule
`default_nettype wire
